// ### rtl/flash_host_pkg.sv
// Constants shared by the flash bus controller.
package flash_host_pkg;
   localparam int CLK_PERIOD_NS = 100;
   // Least low time of the power-down/reset pulse.
   localparam int PD_LOW_NS = 100;
   localparam int PD_LOW_CYC = (PD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Wake-up delays; no figure is given, so these are plain defaults.
   localparam int WAKE_OUT_NS = 1000;
   localparam int WAKE_OUT_CYC = (WAKE_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_WR_NS = 1000;
   localparam int WAKE_WR_CYC = (WAKE_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Bus cycle phase lengths in clock cycles.
   localparam int SETUP_CYC = 1;
   localparam int STROBE_CYC = 2;
   localparam int HOLD_CYC = 1;
   localparam logic [7:0] CNT_W = 8'h08;
   // Memory map: sixteen 64K-byte blocks.
   localparam logic [19:0] BLOCK_SIZE = 20'h10000;
   localparam int BLOCK_SHIFT = 16;
   localparam logic [19:0] TOP_BLOCK_BASE = 20'hF0000;
   // Controller registers.
   localparam logic [3:0] REG_ADDR = 4'h0;
   localparam logic [3:0] REG_WDATA = 4'h1;
   localparam logic [3:0] REG_CMD = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_RDATA = 4'h4;
   // Command register codes.
   localparam logic [1:0] CMD_READ = 2'h1;
   localparam logic [1:0] CMD_WRITE = 2'h2;
   localparam logic [1:0] CMD_RESET = 2'h3;
   // Status bits.
   localparam int ST_BUSY = 0;
   localparam int ST_READY = 1;
   localparam int ST_WAKE_OK = 2;
   localparam int ST_WR_OK = 3;
   localparam int ST_REJECT = 4;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   typedef enum logic [2:0] {
      S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_RESET_LOW
   } host_state_t;
endpackage

// ### rtl/flash_bus_mode_control.sv
// Host-side controller driving an 8-bit asynchronous flash memory through its pins.
// Summary of operation
// RL1 - Flash enters array read after power-up or wake without a command.
// RL2 - Status and identifier reads work at any program supply level.
// RL3 - Flash refuses alterations while program supply is at lockout level.
// RL4 - Alterations need two writes; software issues both writes in sequence.
// RL5 - Flash disables writes at low core supply or reset pin low.
// RL6 - Flash lock bits gate erase and byte write per block.
// RL7 - Sixteen 64K-byte blocks; block n starts at n times 0x10000.
// RL8 - Read: select and output gate low, write strobe high, reset high.
// RL9 - Output gate high floats the flash data pins.
// RL10 - Chip select high gives standby with data pins floating.
// RL11 - Deselecting the flash does not stop a running alteration.
// RL12 - Reset pin low starts deep power-down.
// RL13 - Controller holds reset pin low at least 100 ns.
// RL14 - Wake resets command interface to array read, status 80H.
// RL15 - Controller flags read data captured before the wake-to-output delay passes.
// RL16 - Reset low aborts an alteration; ready/busy stays low until done.
// RL17 - Controller waits the wake-to-write delay before writing a command.
// RL18 - The reset pin follows the controller's own system reset.
// RL19 - Identifier reads return maker, device and lock configuration codes.
// RL20 - Software supplies an address inside the target block or device.
// RL21 - Writes latch on the first rising edge of strobe or select.
// RL22 - Ready/busy low while the flash runs an internal operation.
// RL23 - Unlock high voltage on reset pin overrides block lock bits.
// RL24 - Controller never drives output gate and write strobe low together.
// RL25 - Controller refuses new writes while ready/busy shows busy.
module flash_bus_mode_control
   import flash_host_pkg::*;
(
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Register port.
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Flash pins.
   output logic [19:0] flash_addr_out,
   output logic chip_select_n_out,
   output logic output_gate_n_out,
   output logic write_strobe_n_out,
   output logic powerdown_reset_n_out,
   input wire logic [7:0] data_pins_in,
   output logic [7:0] data_pins_out,
   output logic data_pins_oe_n_out,
   input wire logic ready_busy_n_in
);

   host_state_t state_ff;
   logic [7:0] cnt_ff;
   logic is_read_ff;
   logic [19:0] addr_ff;
   logic [7:0] wdata_ff;
   logic [7:0] rdata_ff;
   logic reject_ff;
   logic [7:0] wake_out_ff;
   logic [7:0] wake_wr_ff;
   logic [1:0] rb_sync_ff;
   logic [7:0] dq_s1_ff;
   logic [7:0] dq_s2_ff;
   logic ready_s;
   logic wake_out_ok;
   logic wake_wr_ok;
   logic [1:0] cmd;
   logic go_rd;
   logic go_wr;
   logic go_rst;
   logic capture;
   logic wr_refused;

   function automatic logic [7:0] cyc8(input int n);
      cyc8 = 8'(n - 1);
   endfunction

   // True while a bus cycle holds the flash selected.
   function automatic logic in_cycle(input host_state_t s);
      in_cycle = (s == S_SETUP) || (s == S_STROBE) || (s == S_HOLD);
   endfunction

   assign ready_s = rb_sync_ff[1];
   assign wake_out_ok = (wake_out_ff == 8'h00);
   assign wake_wr_ok = (wake_wr_ff == 8'h00);
   assign cmd = reg_wdata_in[1:0];
   assign go_rd = reg_wr_in && reg_addr_in == REG_CMD && cmd == CMD_READ && state_ff == S_IDLE;
   // Writes wait for wake-to-write delay and an idle flash.
   assign go_wr = reg_wr_in && reg_addr_in == REG_CMD && cmd == CMD_WRITE && state_ff == S_IDLE
                  && wake_wr_ok && ready_s; // RL17 RL25
   assign go_rst = reg_wr_in && reg_addr_in == REG_CMD && cmd == CMD_RESET && state_ff == S_IDLE;
   assign capture = state_ff == S_STROBE && is_read_ff && cnt_ff == 8'h00;
   assign wr_refused = reg_wr_in && reg_addr_in == REG_CMD && cmd == CMD_WRITE && !go_wr;

   // Ready/busy crosses two flip-flops since the flash drives it freely.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rb_sync_ff <= 2'b00;
      end else begin
         rb_sync_ff <= {rb_sync_ff[0], ready_busy_n_in}; // RL22
      end
   end

   // Data pins cross two flip-flops; the long read strobe covers that delay.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         dq_s1_ff <= 8'h00;
         dq_s2_ff <= 8'h00;
      end else begin
         dq_s1_ff <= data_pins_in;
         dq_s2_ff <= dq_s1_ff;
      end
   end

   // Address staging; ignored while a cycle runs so the pins stay steady.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         addr_ff <= 20'h00000;
      end else if (reg_wr_in && reg_addr_in == REG_ADDR && state_ff == S_IDLE) begin
         addr_ff <= reg_wdata_in[19:0]; // RL20 RL7
      end
   end

   // Write data staging; only the low byte reaches the data pins.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wdata_ff <= 8'h00;
      end else if (reg_wr_in && reg_addr_in == REG_WDATA && state_ff == S_IDLE) begin
         wdata_ff <= reg_wdata_in[7:0];
      end
   end

   // Sequencer for read, write and reset pulse cycles.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_ff <= S_RESET_LOW;
         cnt_ff <= cyc8(PD_LOW_CYC);
         is_read_ff <= 1'b0;
      end else begin
         case (state_ff)
            S_IDLE: begin
               if (go_rd || go_wr) begin
                  state_ff <= S_SETUP;
                  cnt_ff <= cyc8(SETUP_CYC);
                  is_read_ff <= go_rd;
               end else if (go_rst) begin
                  state_ff <= S_RESET_LOW;
                  cnt_ff <= cyc8(PD_LOW_CYC); // RL13
               end
            end
            S_SETUP: begin
               if (cnt_ff == 8'h00) begin
                  state_ff <= S_STROBE;
                  cnt_ff <= cyc8(STROBE_CYC) + (is_read_ff ? CNT_W : 8'h00);
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            S_STROBE: begin
               if (cnt_ff == 8'h00) begin
                  state_ff <= S_HOLD;
                  cnt_ff <= cyc8(HOLD_CYC);
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            S_HOLD: begin
               if (cnt_ff == 8'h00) begin
                  state_ff <= S_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            S_RESET_LOW: begin
               if (cnt_ff == 8'h00) begin
                  state_ff <= S_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   // Wake-to-output timer restarts on every release of the reset pin.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || state_ff == S_RESET_LOW) begin
         wake_out_ff <= cyc8(WAKE_OUT_CYC) + 8'h01;
      end else if (!wake_out_ok) begin
         wake_out_ff <= wake_out_ff - 8'h01; // RL15
      end
   end

   // Wake-to-write timer; the setup cycles add margin beyond the delay.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || state_ff == S_RESET_LOW) begin
         wake_wr_ff <= cyc8(WAKE_WR_CYC) + 8'h01;
      end else if (!wake_wr_ok) begin
         wake_wr_ff <= wake_wr_ff - 8'h01; // RL17
      end
   end

   // Reset pin follows the system reset and the reset pulse.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         powerdown_reset_n_out <= 1'b0; // RL18
      end else begin
         powerdown_reset_n_out <= !(state_ff == S_RESET_LOW); // RL12 RL13 RL16
      end
   end

   // Address and write data are presented from the staging registers.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         flash_addr_out <= 20'h00000;
         data_pins_out <= 8'h00;
      end else begin
         flash_addr_out <= addr_ff; // RL20
         data_pins_out <= wdata_ff;
      end
   end

   // Chip select spans setup, strobe and hold of every cycle.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         chip_select_n_out <= 1'b1;
      end else begin
         chip_select_n_out <= !in_cycle(state_ff); // RL10
      end
   end

   // Output gate opens only in the strobe phase of a read.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         output_gate_n_out <= 1'b1;
      end else begin
         output_gate_n_out <= !(is_read_ff && state_ff == S_STROBE); // RL8 RL24
      end
   end

   // Strobe rises one hold cycle before select so it latches first.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         write_strobe_n_out <= 1'b1;
      end else begin
         write_strobe_n_out <= !(!is_read_ff && state_ff == S_STROBE); // RL21 RL4 RL24
      end
   end

   // The bus stays released during reads so the flash may drive it.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         data_pins_oe_n_out <= 1'b1;
      end else begin
         data_pins_oe_n_out <= !(!is_read_ff && in_cycle(state_ff)); // RL9
      end
   end

   // Read capture at the end of the strobe.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_ff <= 8'h00;
      end else if (capture) begin
         rdata_ff <= dq_s2_ff; // RL2
      end
   end

   // Reject flag: a read before the wake delay or a refused write sets it.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         reject_ff <= 1'b0;
      end else if (capture) begin
         reject_ff <= !wake_out_ok; // RL15
      end else if (wr_refused) begin
         reject_ff <= 1'b1; // RL25
      end else if (go_rd || go_wr) begin
         reject_ff <= 1'b0;
      end
   end

   // Register read port.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 32'h00000000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            REG_ADDR: reg_rdata_out <= {12'h000, addr_ff};
            REG_WDATA: reg_rdata_out <= {24'h000000, wdata_ff};
            REG_RDATA: reg_rdata_out <= {24'h000000, rdata_ff};
            REG_STATUS: begin
               reg_rdata_out <= {27'h0000000, reject_ff, wake_wr_ok, wake_out_ok, ready_s,
                                 state_ff != S_IDLE};
            end
            default: reg_rdata_out <= 32'h00000000;
         endcase
      end else begin
         reg_rdata_out <= 32'h00000000;
      end
   end

endmodule // flash_bus_mode_control

// ### sim/flash_bus_mode_control_properties.sv
// Pin-level properties of the flash bus controller.
module flash_bus_props (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic chip_select_n_out,
   input wire logic output_gate_n_out,
   input wire logic write_strobe_n_out,
   input wire logic powerdown_reset_n_out,
   input wire logic [7:0] data_pins_out,
   input wire logic data_pins_oe_n_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_gate_strobe_apart: assert property (output_gate_n_out || write_strobe_n_out)
      else $error("gate and strobe low together");
   a_read_pins: assert property (!output_gate_n_out |-> !chip_select_n_out
      && data_pins_oe_n_out && write_strobe_n_out && powerdown_reset_n_out)
      else $error("bad pins in read");
   a_write_pins: assert property (!write_strobe_n_out |-> !chip_select_n_out
      && !data_pins_oe_n_out && powerdown_reset_n_out)
      else $error("bad pins in write");
   a_strobe_width: assert property ($fell(write_strobe_n_out) |=> !write_strobe_n_out
      ##1 write_strobe_n_out)
      else $error("strobe width wrong");
   a_latch_order: assert property ($rose(write_strobe_n_out) |-> !chip_select_n_out
      && !data_pins_oe_n_out ##1 chip_select_n_out)
      else $error("select rose before strobe");
   a_data_stable: assert property (!write_strobe_n_out |-> $stable(data_pins_out))
      else $error("data moved under strobe");
   a_pd_hold: assert property ($rose(rst_n_in) |-> !powerdown_reset_n_out)
      else $error("reset pin released early");
   a_wake_write: assert property ($rose(powerdown_reset_n_out) |->
      write_strobe_n_out [*8])
      else $error("write too soon after wake");
   a_pd_quiet: assert property (!powerdown_reset_n_out |-> chip_select_n_out
      && output_gate_n_out && write_strobe_n_out && data_pins_oe_n_out)
      else $error("pins active in power-down");
endmodule // flash_bus_props

bind flash_bus_mode_control flash_bus_props u_props (.clk_in, .rst_n_in, .chip_select_n_out,
   .output_gate_n_out, .write_strobe_n_out, .powerdown_reset_n_out, .data_pins_out,
   .data_pins_oe_n_out);

// ### sim/flash_model.sv
// Behavioural flash memory as seen at its pins.
module flash_model #(
   parameter int BUSY_CYC = 20,
   // Program supply above lockout, per-block lock bits and unlock voltage on the reset pin.
   parameter bit SUPPLY_OK = 1'b1,
   parameter logic [15:0] LOCKED = 16'h0000,
   parameter bit UNLOCK_HV = 1'b0
) (
   input wire logic clk_in,
   input wire logic [19:0] addr_in,
   input wire logic cs_n_in,
   input wire logic og_n_in,
   input wire logic we_n_in,
   input wire logic pd_n_in,
   input wire logic [7:0] bus_in,
   output logic [7:0] q_out,
   output logic ready_busy_n_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [logic [19:0]];
   int busy = 0;
   // Unwritten bytes read as block number and low nibble, so a wrong block shows.
   function automatic logic [7:0] rd_byte(input logic [19:0] a);
      return mem.exists(a) ? mem[a] : {a[19:16], a[3:0]};
   endfunction
   initial q_out = 8'h00;
   // Released pins show the inverse of the last value, as no pull is fitted.
   always @(addr_in, cs_n_in, og_n_in, we_n_in, pd_n_in) begin
      if (!cs_n_in && !og_n_in && we_n_in && pd_n_in) q_out = rd_byte(addr_in);
      else q_out = ~q_out;
   end
   always @(posedge we_n_in) begin
      if (!cs_n_in && pd_n_in && ready_busy_n_out && SUPPLY_OK
          && (!LOCKED[addr_in[19:16]] || UNLOCK_HV)) begin
         mem[addr_in] = bus_in;
         busy = BUSY_CYC;
      end
   end
   always @(posedge clk_in) begin
      if (!pd_n_in) busy = 0;
      else if (busy > 0) busy = busy - 1;
   end
   assign ready_busy_n_out = (busy == 0);
endmodule // flash_model

// ### sim/tb_flash_bus_mode_control.sv
// Self-checking bench for the flash bus controller.
module tb_flash_bus_mode_control;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_host_pkg::*;
   logic clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic [3:0] reg_addr_in = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
   logic [19:0] flash_addr_out;
   logic cs_n, og_n, we_n, pd_n, oe_n, rb_n;
   logic [7:0] dout, din, fq;
   int fail_count = 0, num_checks = 0;
   always #50 clk_in = ~clk_in;
   assign din = oe_n ? fq : dout;
   flash_bus_mode_control u_dut (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .flash_addr_out, .chip_select_n_out(cs_n),
      .output_gate_n_out(og_n), .write_strobe_n_out(we_n), .powerdown_reset_n_out(pd_n),
      .data_pins_in(din), .data_pins_out(dout), .data_pins_oe_n_out(oe_n),
      .ready_busy_n_in(rb_n));
   flash_model u_flash (.clk_in, .addr_in(flash_addr_out), .cs_n_in(cs_n), .og_n_in(og_n),
      .we_n_in(we_n), .pd_n_in(pd_n), .bus_in(din), .q_out(fq), .ready_busy_n_out(rb_n));
   task automatic finish_test();
      if (fail_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 d = reg_rdata_out;
   endtask
   // Polls a status bit; a hang here ends the run as a failure.
   task automatic wait_bit(input int b, input logic v);
      logic [31:0] s;
      for (int i = 0; i < 100; i++) begin
         rd(REG_STATUS, s);
         if (s[b] === v) return;
      end
      fail_count++;
      finish_test();
   endtask
   task automatic op(input logic [1:0] c, input logic [19:0] a, input logic [7:0] d);
      wr(REG_ADDR, {12'h000, a});
      wr(REG_WDATA, {24'h000000, d});
      wr(REG_CMD, {30'h0, c});
      wait_bit(ST_BUSY, 1'b0);
   endtask
   task automatic rd_chk(input logic [19:0] a, input logic [7:0] e);
      logic [31:0] d;
      op(CMD_READ, a, 8'h00);
      rd(REG_RDATA, d);
      chk("read_byte", {24'h0, e}, {24'h0, d[7:0]});
   endtask
   task automatic t_wake();
      logic [31:0] s;
      repeat (3) @(posedge clk_in);
      wr(REG_CMD, {30'h0, CMD_WRITE});
      rd(REG_STATUS, s);
      chk("early_reject", 32'h1, {31'h0, s[ST_REJECT]});
      wait_bit(ST_WR_OK, 1'b1);
      rd(REG_STATUS, s);
      chk("wake_out_ok", 32'h1, {31'h0, s[ST_WAKE_OK]});
   endtask
   task automatic t_write_read();
      logic [31:0] d;
      op(CMD_WRITE, TOP_BLOCK_BASE + 20'h00003, 8'h5A);
      rd(REG_ADDR, d);
      chk("addr_readback", {12'h000, TOP_BLOCK_BASE + 20'h00003}, d);
      wait_bit(ST_READY, 1'b1);
      rd_chk(TOP_BLOCK_BASE + 20'h00003, 8'h5A);
      for (int n = 1; n < 16; n += 14) rd_chk({4'(n), 16'h0001}, {4'(n), 4'h1});
   endtask
   // A second write while the flash is still busy must be refused and leave memory alone.
   task automatic t_refuse();
      logic [31:0] s;
      op(CMD_WRITE, 20'h20000, 8'h11);
      op(CMD_WRITE, 20'h20000, 8'hEE);
      rd(REG_STATUS, s);
      chk("busy_reject", 32'h1, {31'h0, s[ST_REJECT]});
      chk("ready_low", 32'h0, {31'h0, s[ST_READY]});
      wait_bit(ST_READY, 1'b1);
      rd_chk(20'h20000, 8'h11);
      rd(REG_STATUS, s);
      chk("reject_clear", 32'h0, {31'h0, s[ST_REJECT]});
   endtask
   task automatic t_reset();
      int i;
      int n;
      wr(REG_CMD, {30'h0, CMD_RESET});
      for (i = 0; i < 20 && pd_n !== 1'b0; i++) @(negedge clk_in);
      chk("pd_low", 32'h0, {31'h0, pd_n});
      for (n = 0; n < 20 && pd_n === 1'b0; n++) @(negedge clk_in);
      chk("pd_low_cycles", PD_LOW_CYC, n);
      wait_bit(ST_WR_OK, 1'b1);
      rd_chk(TOP_BLOCK_BASE + 20'h00003, 8'h5A);
   endtask
   // A mid-run system reset must pull the reset pin low and leave the flash readable.
   task automatic t_sys_reset();
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk("pd_in_reset", 32'h0, {31'h0, pd_n});
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      wait_bit(ST_WR_OK, 1'b1);
      rd_chk(20'h20000, 8'h11);
   endtask
   initial begin
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_wake();
      t_write_read();
      t_refuse();
      t_reset();
      t_sys_reset();
      finish_test();
   end
endmodule // tb_flash_bus_mode_control
